// ==== logic/panel_key_matrix_scanner.sv ====
// Front panel key matrix scanner with debounce and two-key rollover
`default_nettype none

module panel_key_matrix_scanner
	import key_scan_pkg::*;
#(
	parameter int SCAN_DIV = SCAN_DIV_CYC
)(
	input  wire logic             sys_clk,             // System clock, 100 MHz
	input  wire logic             rst,                 // Async reset, active high
	input  wire logic [COLS-1:0]  column_n,            // Column lines, low = closed key
	output logic      [ROWS-1:0]  row_drive_n,         // Row lines, one low at a time
	input  wire logic             host_read,           // Host read the latch, one pulse
	output logic                  key_change_strobe_n, // Change pending, active low
	output logic                  key_polarity,        // 1 = key now closed
	output logic      [POS_W-1:0] key_position,        // Row and column of key
	output logic                  scan_hold,           // Scanning stopped for rollover
	output logic                  panel_scan_clock     // Scan step enable pulse
);

	scan_state_s      s_q;
	scan_state_s      s_d;
	logic             tick;
	logic [SEL_W-1:0] sel_col;
	logic             sel_out_n;
	logic             sample;
	logic             confirm;
	key_event_s       ev;

	// ****************************************
	// Scan step divider
	// ****************************************
	scan_divider #(
		.DIV     (SCAN_DIV)
	) u_div (
		.sys_clk (sys_clk),
		.rst     (rst),
		.run     (s_q.st != ST_HOLD),
		.tick    (tick)
	);

	assign panel_scan_clock = tick;

	// ****************************************
	// Key selection
	// ****************************************
	// Low three bits of the scan position pick the column, top two the row
	assign sel_col = s_q.pos[SEL_W-1:0];                 // [RL1]
	// Only the driven row can pull a column low, so one key is seen
	assign sel_out_n = column_n[sel_col];                // [RL4] [RL5]
	assign sample = ~sel_out_n;

	// Row decoder: drive the addressed row low, release the others
	function automatic logic [ROWS-1:0] row_decode(input logic [1:0] r);
		row_decode = ~(ROWS'(1) << r);
	endfunction

	// ****************************************
	// Scan, debounce and report
	// ****************************************
	// Only one candidate is tracked; other changes are caught on later passes
	always_comb
	begin
		s_d = s_q;
		confirm = 1'b0;
		ev = '{valid: 1'b1, pos: s_q.cand_pos, pol: s_q.cand_val};
		// Host read frees the latch; a held second change moves in behind it
		if (host_read)
		begin
			s_d.rep.valid = 1'b0;                        // [RL10]
			if (s_q.held.valid)
			begin
				s_d.rep = s_q.held;                      // [RL13]
				s_d.held.valid = 1'b0;
				s_d.st = ST_SCAN;
			end
		end
		if (tick && s_q.st != ST_HOLD)
		begin
			case (s_q.st)
				ST_SCAN:
				begin
					if (sample != s_q.keys[s_q.pos])
					begin
						s_d.cand_pos = s_q.pos;
						s_d.cand_val = sample;
						// Oldest stage keeps the pre-change state
						s_d.sh = {{(SHIFT_DEPTH-1){s_q.keys[s_q.pos]}}, sample}; // [RL6]
						s_d.st = ST_TRACK;
					end
				end
				ST_TRACK:
				begin
					if (s_q.pos == s_q.cand_pos)
					begin
						s_d.sh = {s_q.sh[SHIFT_DEPTH-2:0], sample}; // [RL6]
						if (sample != s_q.cand_val)
						begin
							// Bounce: drop the candidate and look again
							s_d.st = ST_SCAN;
						end
						else if (s_q.sh[1:0] == {2{s_q.cand_val}})
						begin
							confirm = 1'b1;              // [RL7] [RL12]
						end
					end
				end
				default:
				begin
					s_d.st = ST_SCAN;
				end
			endcase
			// Step to the next key and its row
			s_d.pos = s_q.pos + 5'h01;                   // [RL2]
			s_d.row_n = row_decode(s_d.pos[POS_W-1:SEL_W]); // [RL3]
		end
		if (confirm)
		begin
			s_d.keys[s_q.cand_pos] = s_q.cand_val;
			s_d.st = ST_SCAN;
			// A change confirmed in the read cycle is not lost
			if (!s_d.rep.valid)
			begin
				s_d.rep = ev;                            // [RL8] [RL9] [RL11]
			end
			else
			begin
				s_d.held = ev;
				s_d.st = ST_HOLD;                        // [RL13]
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			s_q <= SCAN_RESET;
		else
			s_q <= s_d;
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Latch content stands until the host reads it
	assign row_drive_n = s_q.row_n;
	assign key_change_strobe_n = ~s_q.rep.valid;          // [RL10] [RL14]
	assign key_polarity = s_q.rep.pol;                    // [RL8] [RL11]
	assign key_position = s_q.rep.pos;                    // [RL9] [RL11]
	assign scan_hold = (s_q.st == ST_HOLD);               // [RL13]

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_second_change;
		confirm && !key_change_strobe_n && !host_read;
	endsequence

	sequence s_host_catchup;
		scan_hold && host_read;
	endsequence

	property p_step_hold;
		!tick |=> $stable(s_q.pos);
	endproperty
	a_step_hold: assert property (p_step_hold) else $error("scan moved off step"); // [RL2]

	property p_step_advance;
		tick && !scan_hold |=> s_q.pos == $past(s_q.pos) + 5'h01;
	endproperty
	a_step_advance: assert property (p_step_advance) else $error("scan did not step"); // [RL2]

	property p_one_row;
		$onehot(~row_drive_n) && !row_drive_n[s_q.pos[POS_W-1:SEL_W]];
	endproperty
	a_one_row: assert property (p_one_row) else $error("row drive not one-hot"); // [RL3]

	property p_detect;
		tick && s_q.st == ST_SCAN && !column_n[s_q.pos[SEL_W-1:0]] && !s_q.keys[s_q.pos]
		|=> s_q.st == ST_TRACK && s_q.cand_pos == $past(s_q.pos) && s_q.sh[0];
	endproperty
	a_detect: assert property (p_detect) else $error("closed key not tracked"); // [RL5]

	property p_confirm;
		confirm
		|-> s_q.st == ST_TRACK && s_q.sh[1:0] == {2{s_q.cand_val}} && sample == s_q.cand_val;
	endproperty
	a_confirm: assert property (p_confirm) else $error("change confirmed early"); // [RL7]

	property p_report;
		$fell(key_change_strobe_n)
		|-> key_polarity == $past(s_q.cand_val) && key_position == $past(s_q.cand_pos);
	endproperty
	a_report: assert property (p_report) else $error("latched key or polarity wrong"); // [RL8]

	property p_latch_stable;
		!key_change_strobe_n && !host_read
		|=> !key_change_strobe_n && $stable(key_position) && $stable(key_polarity);
	endproperty
	a_latch_stable: assert property (p_latch_stable) else $error("latch changed unread"); // [RL14]

	property p_rollover;
		s_second_change |=> scan_hold && !key_change_strobe_n;
	endproperty
	a_rollover: assert property (p_rollover) else $error("second change not held"); // [RL13]

	property p_hold_frozen;
		scan_hold |=> $stable(s_q.pos);
	endproperty
	a_hold_frozen: assert property (p_hold_frozen) else $error("scan ran while held"); // [RL13]

	property p_catchup;
		s_host_catchup
		|=> !scan_hold && !key_change_strobe_n && key_position == $past(s_q.held.pos);
	endproperty
	a_catchup: assert property (p_catchup) else $error("held change not reloaded"); // [RL10]

endmodule

`default_nettype wire

// ==== logic/key_scan_pkg.sv ====
// Constants and carrier types for the front panel key matrix scanner
// How it works
// RL1: Keys join column to row; 8:1 select, 2:4 rows.
// RL2: Scan steps once per 2048 system clocks.
// RL3: Rows driven low one at a time.
// RL4: Closed key on driven row pulls column low.
// RL5: Selector output low when its column low.
// RL6: Samples shift into four-stage debounce register.
// RL7: Change counts after two further agreeing scans.
// RL8: Polarity shows closed after debounced press.
// RL9: Position lines carry scanned key into latch.
// RL10: Strobe interrupts host; host reads the latch.
// RL11: Position plus polarity identify key and direction.
// RL12: Release reported likewise after three scans.
// RL13: Second pending change holds scanning until read.
// RL14: Strobe and latch hold until host reads.
`default_nettype none

package key_scan_pkg;

	// ****************************************
	// Timing and matrix shape
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCAN_DIV_CYC  = 2048;
	localparam int DIV_W         = 11;
	localparam int ROWS          = 4;
	localparam int COLS          = 8;
	localparam int POS_W         = 5;
	localparam int SEL_W         = 3;
	localparam int SHIFT_DEPTH   = 4;

	// ****************************************
	// Types and reset values
	// ****************************************
	typedef enum logic [1:0]
	{
		ST_SCAN  = 2'b00,
		ST_TRACK = 2'b01,
		ST_HOLD  = 2'b11
	} scan_state_e;

	typedef struct packed
	{
		logic             valid;
		logic [POS_W-1:0] pos;
		logic             pol;
	} key_event_s;

	typedef struct packed
	{
		scan_state_e            st;
		logic [POS_W-1:0]       pos;
		logic [ROWS-1:0]        row_n;
		logic [ROWS*COLS-1:0]   keys;
		logic [POS_W-1:0]       cand_pos;
		logic                   cand_val;
		logic [SHIFT_DEPTH-1:0] sh;
		key_event_s             rep;
		key_event_s             held;
	} scan_state_s;

	typedef struct packed
	{
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} div_state_s;

	localparam logic [ROWS-1:0] ROW_RESET  = 4'he;
	localparam scan_state_s     SCAN_RESET = '{st: ST_SCAN, row_n: ROW_RESET, default: '0};
	localparam div_state_s      DIV_RESET  = '{default: '0};

endpackage

`default_nettype wire

// ==== logic/scan_divider.sv ====
// Scan step divider: one-cycle enable every DIV system clocks
`default_nettype none

module scan_divider
	import key_scan_pkg::*;
#(
	parameter int DIV = SCAN_DIV_CYC
)(
	input  wire logic sys_clk, // System clock
	input  wire logic rst,     // Async reset, active high
	input  wire logic run,     // Count enable; low freezes the scan
	output logic      tick     // One-cycle scan step pulse
);

	localparam logic [DIV_W-1:0] LAST = DIV_W'(DIV - 1);

	div_state_s s_q;
	div_state_s s_d;

	// ****************************************
	// Divide the bus clock down to the scan rate
	// ****************************************
	// Counter freezes while held so the step phase survives a rollover stall
	always_comb
	begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (run)
		begin
			if (s_q.cnt == LAST)
			begin
				s_d.cnt = '0;
				s_d.tick = 1'b1; // [RL2]
			end
			else
			begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			s_q <= DIV_RESET;
		else
			s_q <= s_d;
	end

	assign tick = s_q.tick;

endmodule

`default_nettype wire

// ==== sim/key_host.sv ====
// Host model that services key change interrupts by reading the latch
`default_nettype none

module key_host
	import key_scan_pkg::*;
(
	input  wire logic             sys_clk,  // System clock
	input  wire logic             strobe_n, // Change pending
	input  wire logic [POS_W-1:0] pos,      // Latched position
	input  wire logic             pol,      // Latched polarity
	input  wire logic             slow,     // Late service
	output logic                  rd,       // Latch read pulse
	output logic      [POS_W-1:0] ev_pos,   // Last position read
	output logic                  ev_pol,   // Last polarity read
	output int                    ev_cnt,   // Events read
	output logic                  moved     // Latch moved while pending
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		rd = 1'b0;
		ev_cnt = 0;
		moved = 1'b0;
	end

	// A slow host stays away long enough for a second change to need the hold
	always
	begin
		@(posedge sys_clk);
		#1;
		if (strobe_n === 1'b0)
		begin
			ev_pos = pos;
			ev_pol = pol;
			repeat (slow ? 1000 : 1) @(posedge sys_clk);
			#1;
			moved = moved | (pos !== ev_pos) | (pol !== ev_pol);
			rd = 1'b1;
			ev_cnt = ev_cnt + 1;
			@(posedge sys_clk);
			#1;
			rd = 1'b0;
		end
	end
endmodule

`default_nettype wire

// ==== sim/panel_key_matrix_scanner_tb.sv ====
// Self-checking testbench for the panel key matrix scanner
`default_nettype none

module panel_key_matrix_scanner_tb
	import key_scan_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SD   = 4;
	localparam int PASS = 32 * SD;
	// Eight key cycles, the slow-host rollover and the reset case, with margin
	localparam int WATCHDOG = 160 * PASS;
	logic             sys_clk, rst, hrd, strobe_n, pol, hold, tick, slow, moved;
	logic [COLS-1:0]  column_n;
	logic [ROWS-1:0]  row_n, er;
	logic [POS_W-1:0] pos, ev_pos;
	logic             ev_pol;
	logic [31:0]      keys;
	integer           seed;
	int               ev_cnt, mismatches, comparisons, k, gap, lat, i, j, n, p1;
	bit               held_seen, hold_hit;

	panel_key_matrix_scanner #(.SCAN_DIV(SD)) panel_key_matrix_scanner_i (
		.sys_clk(sys_clk), .rst(rst), .column_n(column_n), .row_drive_n(row_n),
		.host_read(hrd), .key_change_strobe_n(strobe_n), .key_polarity(pol),
		.key_position(pos), .scan_hold(hold), .panel_scan_clock(tick));

	key_host key_host_i (.sys_clk(sys_clk), .strobe_n(strobe_n), .pos(pos), .pol(pol),
		.slow(slow), .rd(hrd), .ev_pos(ev_pos), .ev_pol(ev_pol), .ev_cnt(ev_cnt),
		.moved(moved));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Pulled-up columns: a closed key on the low row pulls its column down
	always_comb
	begin
		column_n = '1;
		for (int b = 0; b < 32; b++)
			if (keys[b] && row_n[b / 8] === 1'b0)
				column_n[b % 8] = 1'b0;
	end

	// ****
	// Checks and helpers
	// ****
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s exp %0h got %0h", nm, exp, got);
		end
	endtask

	// Expected row drive for a scan step: eight steps per row, one row low
	function automatic logic [ROWS-1:0] exp_row(int step);
		exp_row = ~(4'h1 << ((step % 32) / 8));
	endfunction

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wait_ev(int n0);
		lat = 0;
		while (ev_cnt == n0 && lat < 12 * PASS)
		begin
			@(posedge sys_clk);
			#1;
			lat++;
		end
		// A report that never comes counts against the run
		chk("ev_wait", 1, ev_cnt != n0);
	endtask

	task automatic press_rel(int x);
		n = ev_cnt;
		keys[x] = 1'b1;
		wait_ev(n);
		chk("press_lat", 1, lat > 2 * PASS && lat <= 3 * PASS + 8);
		chk("press_pos", x, ev_pos);
		chk("press_pol", 1, ev_pol);
		keys[x] = 1'b0;
		wait_ev(n + 1);
		chk("rel_pos", x, ev_pos);
		chk("rel_pol", 0, ev_pol);
		$display("test key %0d done", x);
	endtask

	// Step spacing and row order; spacing is skipped across a rollover hold
	always
	begin
		@(posedge sys_clk);
		#1;
		gap++;
		if (hold === 1'b1)
		begin
			held_seen = 1'b1;
			hold_hit = 1'b1;
		end
		if (rst)
		begin
			k = 0;
			gap = 0;
		end
		else if (tick === 1'b1)
		begin
			if (k > 0 && !held_seen)
				chk("tick_gap", SD, gap);
			er = exp_row(k);
			chk("row", er, row_n);
			k++;
			gap = 0;
			held_seen = 1'b0;
		end
	end

	initial
	begin
		repeat (WATCHDOG) @(posedge sys_clk);
		mismatches++;
		report_and_stop();
	end

	// ****
	// Main sequence
	// ****
	initial
	begin
		seed = 32'h782d;
		rst = 1'b1;
		keys = '0;
		slow = 1'b0;
		hold_hit = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		press_rel(0);
		press_rel(31);
		for (int t = 0; t < 6; t++)
			press_rel($unsigned($random(seed)) % 32);
		// A closure seen on a single visit must be dropped
		n = ev_cnt;
		i = $unsigned($random(seed)) % 32;
		keys[i] = 1'b1;
		repeat (PASS - SD) @(posedge sys_clk);
		#1;
		keys[i] = 1'b0;
		repeat (4 * PASS) @(posedge sys_clk);
		chk("bounce", n, ev_cnt);
		$display("test bounce done");
		// Two presses against a slow host force the rollover hold
		slow = 1'b1;
		j = (i + 13) % 32;
		keys[i] = 1'b1;
		keys[j] = 1'b1;
		wait_ev(n);
		p1 = ev_pos;
		wait_ev(n + 1);
		chk("roll_pair", 1, (p1 == i && ev_pos == j) || (p1 == j && ev_pos == i));
		chk("roll_hold", 1, hold_hit);
		chk("roll_pol", 1, ev_pol);
		slow = 1'b0;
		keys = '0;
		wait_ev(n + 2);
		wait_ev(n + 3);
		chk("roll_rel", n + 4, ev_cnt);
		chk("latch_still", 0, moved);
		$display("test rollover done");
		// Reset in mid-run with a change pending must clear the latch
		slow = 1'b1;
		keys[i] = 1'b1;
		lat = 0;
		while (strobe_n !== 1'b0 && lat < 4 * PASS)
		begin
			@(posedge sys_clk);
			#1;
			lat++;
		end
		chk("rst_pending", 0, strobe_n);
		rst = 1'b1;
		@(posedge sys_clk);
		#1;
		chk("rst_row", 4'he, row_n);
		chk("rst_strobe", 1, strobe_n);
		chk("rst_latch", 0, {hold, pol, pos});
		rst = 1'b0;
		// Key still closed, but debounce starts over, so nothing reports yet
		repeat (2) @(posedge sys_clk);
		#1;
		chk("rst_quiet", 1, strobe_n);
		$display("test reset done");
		report_and_stop();
	end
endmodule

`default_nettype wire
